// file: cte_map.svh
// Register offsets, field positions, reload values and limits of the CAN timestamp,
// error counter and transfer command block.
// Assumes inclusion by bare name from the design modules.
`ifndef CTE_MAP_SVH
`define CTE_MAP_SVH
`define CTE_OFF_MODE 8'h00
`define CTE_OFF_IMASK 8'h04
`define CTE_OFF_STATUS 8'h08
`define CTE_OFF_TIMER 8'h0c
`define CTE_OFF_TSTAMP 8'h10
`define CTE_OFF_ERRCNT 8'h14
`define CTE_OFF_XFER 8'h18
`define CTE_OFF_MBOX_TYPE 8'h1c
`define CTE_OFF_MBOX_PRIO 8'h20
`define CTE_OFF_MBOX_STAT 8'h24
`define CTE_BIT_ENABLE 0
`define CTE_BIT_EOF_SEL 1
`define CTE_BIT_CAPTURE 0
`define CTE_BIT_TIMER_CLR 31
`define CTE_TEC_LSB 16
`define CTE_RDY_LSB 0
`define CTE_ABT_LSB 8
`define CTE_ERR_STEP 8'h08
`define CTE_REC_LIMIT 8'h7f
`define CTE_REC_RELOAD 8'h77
`define CTE_FLAG_TOL_ACTIVE 5'h0d
`define CTE_FLAG_TOL_PASSIVE 5'h07
`define CTE_FLAG_REPEAT 5'h08
`endif

// file: cte_pkg.sv
// Types shared by the CAN timestamp and error counter block.
// Assumes cte_map.svh holds the numeric constants.
package cte_pkg;
  typedef enum logic [2:0] {
    CTE_MB_DISABLED,
    CTE_MB_RECEIVE,
    CTE_MB_RECEIVE_OVR,
    CTE_MB_TRANSMIT,
    CTE_MB_CONSUMER,
    CTE_MB_PRODUCER
  } cte_mbox_type_t;
  typedef enum logic [1:0] {
    CTE_FLAG_ACTIVE,
    CTE_FLAG_PASSIVE,
    CTE_FLAG_OVERLOAD
  } cte_flag_kind_t;
endpackage

// file: cte_err_counter.sv
// One CAN error counter with error-confinement update rules.
// Assumes one-cycle event pulses from the protocol engine, at most one group per cycle.
`timescale 1ns/1ns
`default_nettype none
`include "cte_map.svh"
module cte_err_counter #(
  parameter int WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic inc_one,
  input wire logic inc_eight,
  input wire logic success,
  input wire logic saturate_reload,
  output logic [WIDTH-1:0] count
);
  if (WIDTH < 8) $error("cte_err_counter needs WIDTH of at least 8");
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic [WIDTH:0] sum;
  always_comb begin
    sum = {1'b0, count_reg};
    if (inc_eight) begin
      sum = {1'b0, count_reg} + (WIDTH+1)'(`CTE_ERR_STEP);
    end else if (inc_one) begin
      sum = {1'b0, count_reg} + (WIDTH+1)'(1);
    end
    count_next = sum[WIDTH] ? '1 : sum[WIDTH-1:0];
    if (!inc_eight && !inc_one && success) begin
      if (saturate_reload && count_reg > WIDTH'(`CTE_REC_LIMIT)) begin
        count_next = WIDTH'(`CTE_REC_RELOAD);
      end else if (count_reg != '0) begin
        count_next = count_reg - WIDTH'(1);
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
  assign count = count_reg;
endmodule // cte_err_counter
`default_nettype wire

// file: cte_core.sv
// CAN timer, frame timestamp, error counters and transfer command, behind an AXI4-Lite slave.
// Assumes the protocol engine gives one-cycle event pulses synchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
`include "cte_map.svh"
// Contract
// - Keep a 16-bit free-running timer readable in the timer register.
// - With end-of-frame select clear, capture timer at each start of frame.
// - With end-of-frame select set, capture timer at each end of frame.
// - Every capture sets the capture-done status flag.
// - Interrupt is high while capture flag and its mask bit are set.
// - Reading the status register clears the capture-done flag.
// - Timestamp resets when controller goes disabled then enabled again.
// - Receive errors add one to receive count, except flag bit errors.
// - Dominant first bit after own error flag adds eight to receive count.
// - Bit error in receiver's active error flag adds eight to receive count.
// - Dominant run after flag adds eight at 14th or 8th bit, then every 8.
// - Good reception: 1..127 decrements, 0 holds, above 127 reloads 119..127.
// - Sending error flag adds eight to transmit count except two passive cases.
// - Bit error in transmitter's active or overload flag adds eight.
// - Transmitter dominant run adds eight at 14th or 8th bit, then every 8.
// - Good transmission decrements transmit count unless already zero.
// - Transfer command holds eight mailbox request bits settable in one write.
// - Request acts by mailbox type: receive, send, remote frame, or answer.
// - Setting a request bit clears that mailbox's ready and abort flags.
// - Pending transmits go out highest priority first, lower number on ties.
// - Timer clear command bit 31 zeroes the timer and unfreezes it.
module cte_core #(
  parameter int NUM_MBOX = 8,
  parameter int TIMER_WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic bit_tick,
  input wire logic timer_freeze,
  input wire logic start_of_frame,
  input wire logic end_of_frame,
  input wire logic rx_error,
  input wire logic rx_error_in_flag,
  input wire logic rx_dominant_after_flag,
  input wire logic tx_error_flag_sent,
  input wire logic tx_error_exempt,
  input wire logic tx_error_in_flag,
  input wire logic flag_done,
  input wire logic flag_passive,
  input wire logic bus_dominant,
  input wire logic transmitting,
  input wire logic rx_success,
  input wire logic tx_success,
  input wire logic [NUM_MBOX-1:0] mbox_ready_set,
  input wire logic [NUM_MBOX-1:0] mbox_abort_set,
  input wire logic tx_done,
  output logic [NUM_MBOX-1:0] mbox_rx_arm,
  output logic [NUM_MBOX-1:0] mbox_remote_wait,
  output logic tx_start,
  output logic [2:0] tx_mbox,
  output logic tx_remote,
  output logic irq
);
  if (NUM_MBOX != 8) $error("cte_core serves exactly eight mailboxes");
  if (TIMER_WIDTH != 16) $error("cte_core timer must be 16 bits");
  logic [TIMER_WIDTH-1:0] timer_reg, tstamp_reg;
  logic running_reg, enable_reg, eof_sel_reg, imask_reg, capture_reg, busy_reg;
  logic [NUM_MBOX-1:0] pending_reg, rdy_reg, abt_reg;
  logic [3*NUM_MBOX-1:0] type_reg;
  logic [4*NUM_MBOX-1:0] prio_reg;
  logic [7:0] awaddr_reg;
  logic aw_held_reg, w_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [4:0] dom_run_reg;
  logic dom_active_reg, dom_armed_reg, flag_passive_reg;
  logic [7:0] rx_error_count, tx_error_count;
  // Write channel: address and data latched independently, applied together
  logic wr_fire;
  logic [31:0] wr_mask;
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = a == `CTE_OFF_MODE || a == `CTE_OFF_IMASK || a == `CTE_OFF_STATUS
              || a == `CTE_OFF_TIMER || a == `CTE_OFF_TSTAMP || a == `CTE_OFF_ERRCNT
              || a == `CTE_OFF_XFER || a == `CTE_OFF_MBOX_TYPE || a == `CTE_OFF_MBOX_PRIO
              || a == `CTE_OFF_MBOX_STAT;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known_addr(awaddr_reg) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_mode, wr_imask, wr_xfer, timer_clr;
  logic [NUM_MBOX-1:0] xfer_set;
  assign wr_mode = wr_fire && awaddr_reg == `CTE_OFF_MODE && wstrb_reg[0];
  assign wr_imask = wr_fire && awaddr_reg == `CTE_OFF_IMASK && wstrb_reg[0];
  assign wr_xfer = wr_fire && awaddr_reg == `CTE_OFF_XFER;
  assign xfer_set = wr_xfer && wstrb_reg[0] ? wdata_reg[NUM_MBOX-1:0] : '0;
  assign timer_clr = wr_xfer && wstrb_reg[3] && wdata_reg[`CTE_BIT_TIMER_CLR];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= 1'b0;
      eof_sel_reg <= 1'b0;
      imask_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        enable_reg <= wdata_reg[`CTE_BIT_ENABLE];
        eof_sel_reg <= wdata_reg[`CTE_BIT_EOF_SEL];
      end
      if (wr_imask) begin
        imask_reg <= wdata_reg[`CTE_BIT_CAPTURE];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      type_reg <= '0;
      prio_reg <= '0;
    end else if (wr_fire) begin
      if (awaddr_reg == `CTE_OFF_MBOX_TYPE) begin
        type_reg <= (type_reg & ~wr_mask[3*NUM_MBOX-1:0]) | (wdata_reg[3*NUM_MBOX-1:0] & wr_mask[3*NUM_MBOX-1:0]);
      end
      if (awaddr_reg == `CTE_OFF_MBOX_PRIO) begin
        prio_reg <= (prio_reg & ~wr_mask) | (wdata_reg & wr_mask);
      end
    end
  end

  // Timer and timestamp capture
  logic capture_evt;
  assign capture_evt = enable_reg && (eof_sel_reg ? end_of_frame : start_of_frame);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_reg <= '0;
      running_reg <= 1'b1;
    end else if (timer_clr) begin
      timer_reg <= '0;
      running_reg <= 1'b1;
    end else begin
      if (timer_freeze) begin
        running_reg <= 1'b0;
      end
      if (running_reg && enable_reg && bit_tick && !timer_freeze) begin
        timer_reg <= timer_reg + TIMER_WIDTH'(1);
      end
    end
  end
  logic enable_rise;
  assign enable_rise = wr_mode && wdata_reg[`CTE_BIT_ENABLE] && !enable_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tstamp_reg <= '0;
    end else if (capture_evt) begin
      tstamp_reg <= timer_reg;
    end else if (enable_rise) begin
      tstamp_reg <= '0;
    end
  end
  logic rd_status;
  assign rd_status = s_axi_arvalid && s_axi_arready && {s_axi_araddr[7:2], 2'h0} == `CTE_OFF_STATUS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_reg <= 1'b0;
    end else if (capture_evt) begin
      capture_reg <= 1'b1;
    end else if (rd_status) begin
      capture_reg <= 1'b0;
    end
  end
  assign irq = capture_reg && imask_reg;
  // Dominant-bit run after a flag
  logic run_hit;
  assign run_hit = dom_active_reg && bit_tick && bus_dominant
                && (dom_armed_reg ? dom_run_reg == `CTE_FLAG_REPEAT - 5'h01
                   : dom_run_reg == (flag_passive_reg ? `CTE_FLAG_TOL_PASSIVE : `CTE_FLAG_TOL_ACTIVE));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dom_active_reg <= 1'b0;
      dom_armed_reg <= 1'b0;
      dom_run_reg <= 5'h00;
      flag_passive_reg <= 1'b0;
    end else if (flag_done) begin
      dom_active_reg <= 1'b1;
      dom_armed_reg <= 1'b0;
      dom_run_reg <= 5'h00;
      flag_passive_reg <= flag_passive;
    end else if (dom_active_reg && bit_tick) begin
      if (!bus_dominant) begin
        dom_active_reg <= 1'b0;
      end else if (run_hit) begin
        dom_armed_reg <= 1'b1;
        dom_run_reg <= 5'h00;
      end else begin
        dom_run_reg <= dom_run_reg + 5'h01;
      end
    end
  end

  cte_err_counter #(.WIDTH(8)) u_rec (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_one(rx_error && !rx_error_in_flag),
    .inc_eight(rx_dominant_after_flag || rx_error_in_flag || (run_hit && !transmitting)),
    .success(rx_success),
    .saturate_reload(1'b1),
    .count(rx_error_count)
  );

  cte_err_counter #(.WIDTH(8)) u_tec (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_one(1'b0),
    .inc_eight((tx_error_flag_sent && !tx_error_exempt) || tx_error_in_flag || (run_hit && transmitting)),
    .success(tx_success),
    .saturate_reload(1'b0),
    .count(tx_error_count)
  );

  // Mailbox requests, flags and transmit arbitration
  function automatic cte_pkg::cte_mbox_type_t mb_type(input logic [3*NUM_MBOX-1:0] t, input int i);
    mb_type = cte_pkg::cte_mbox_type_t'(t[3*i +: 3]);
  endfunction
  logic [NUM_MBOX-1:0] tx_kind, rx_kind;
  for (genvar g = 0; g < NUM_MBOX; g++) begin : g_kind
    assign tx_kind[g] = mb_type(type_reg, g) == cte_pkg::CTE_MB_TRANSMIT || mb_type(type_reg, g) == cte_pkg::CTE_MB_CONSUMER;
    assign rx_kind[g] = mb_type(type_reg, g) == cte_pkg::CTE_MB_RECEIVE || mb_type(type_reg, g) == cte_pkg::CTE_MB_RECEIVE_OVR;
  end

  logic found;
  logic [2:0] win;
  logic [3:0] win_prio;
  always_comb begin
    found = 1'b0;
    win = 3'h0;
    win_prio = 4'h0;
    for (int i = 0; i < NUM_MBOX; i++) begin
      if (pending_reg[i] && tx_kind[i] && (!found || prio_reg[4*i +: 4] < win_prio)) begin
        found = 1'b1;
        win = 3'(i);
        win_prio = prio_reg[4*i +: 4];
      end
    end
  end
  logic launch;
  assign launch = found && !busy_reg && enable_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_reg <= '0;
      rdy_reg <= '0;
      abt_reg <= '0;
      mbox_rx_arm <= '0;
      mbox_remote_wait <= '0;
    end else begin
      for (int i = 0; i < NUM_MBOX; i++) begin
        if (xfer_set[i]) begin
          pending_reg[i] <= tx_kind[i];
          mbox_rx_arm[i] <= rx_kind[i];
          mbox_remote_wait[i] <= mb_type(type_reg, i) == cte_pkg::CTE_MB_PRODUCER;
          rdy_reg[i] <= mbox_ready_set[i];
          abt_reg[i] <= mbox_abort_set[i];
        end else begin
          if (launch && win == 3'(i)) begin
            pending_reg[i] <= 1'b0;
          end
          rdy_reg[i] <= rdy_reg[i] | mbox_ready_set[i];
          abt_reg[i] <= abt_reg[i] | mbox_abort_set[i];
          if (mbox_ready_set[i]) begin
            mbox_rx_arm[i] <= 1'b0;
            mbox_remote_wait[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_reg <= 1'b0;
      tx_start <= 1'b0;
      tx_mbox <= 3'h0;
      tx_remote <= 1'b0;
    end else begin
      tx_start <= launch;
      if (launch) begin
        busy_reg <= 1'b1;
        tx_mbox <= win;
        tx_remote <= mb_type(type_reg, int'(win)) == cte_pkg::CTE_MB_CONSUMER;
      end else if (tx_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= known_addr({s_axi_araddr[7:2], 2'h0}) ? 2'h0 : 2'h2;
      unique case ({s_axi_araddr[7:2], 2'h0})
        `CTE_OFF_MODE: s_axi_rdata <= {30'h0, eof_sel_reg, enable_reg};
        `CTE_OFF_IMASK: s_axi_rdata <= {31'h0, imask_reg};
        `CTE_OFF_STATUS: s_axi_rdata <= {31'h0, capture_reg};
        `CTE_OFF_TIMER: s_axi_rdata <= {16'h0, timer_reg};
        `CTE_OFF_TSTAMP: s_axi_rdata <= {16'h0, tstamp_reg};
        `CTE_OFF_ERRCNT: s_axi_rdata <= {8'h0, tx_error_count, 8'h0, rx_error_count};
        `CTE_OFF_MBOX_TYPE: s_axi_rdata <= {8'h0, type_reg};
        `CTE_OFF_MBOX_PRIO: s_axi_rdata <= prio_reg;
        `CTE_OFF_MBOX_STAT: s_axi_rdata <= {16'h0, abt_reg, rdy_reg};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // cte_core
`default_nettype wire

// file: cte_core_assertions.sv
// Port-level checker for the CAN timer, timestamp and error counter block.
// Assumes it is bound to cte_core and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module cte_core_assertions #(
  parameter int NUM_MBOX = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic start_of_frame,
  input wire logic end_of_frame,
  input wire logic tx_start,
  input wire logic tx_remote,
  input wire logic tx_done,
  input wire logic irq,
  input wire logic [NUM_MBOX-1:0] mbox_ready_set,
  input wire logic [NUM_MBOX-1:0] mbox_rx_arm,
  input wire logic [NUM_MBOX-1:0] mbox_remote_wait
);
  logic busy_reg;
  logic wr_hs;
  assign wr_hs = (s_axi_wvalid && s_axi_wready) || (s_axi_awvalid && s_axi_awready);
  // Tracks a transmit in flight so a second launch can be caught
  always_ff @(posedge aclk) begin
    if (!aresetn) busy_reg <= 1'b0;
    else if (tx_start) busy_reg <= 1'b1;
    else if (tx_done) busy_reg <= 1'b0;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_xfer_reads_zero: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h18 |=> s_axi_rvalid && s_axi_rdata == 32'h0)
    else $error("transfer command read not zero");
  a_one_tx_busy: assert property (tx_start |-> !busy_reg)
    else $error("launch while a transmit is in flight");
  a_rx_arm_clear: assert property (
    mbox_ready_set != '0 && !$past(wr_hs) |=> (mbox_rx_arm & $past(mbox_ready_set)) == '0)
    else $error("receive arm kept after ready");
  a_remote_wait_clear: assert property (
    mbox_ready_set != '0 && !$past(wr_hs) |=> (mbox_remote_wait & $past(mbox_ready_set)) == '0)
    else $error("remote wait kept after ready");
  a_status_read_irq: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h08 && !start_of_frame && !end_of_frame
    ##1 !start_of_frame && !end_of_frame |-> !irq)
    else $error("irq kept after status read");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_start_pulse: assert property (tx_start |=> !tx_start)
    else $error("transmit start longer than one cycle");
  c_remote: cover property (tx_start && tx_remote);
  c_irq: cover property ($rose(irq));
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // cte_core_assertions
bind cte_core cte_core_assertions #(.NUM_MBOX(NUM_MBOX)) u_chk (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .start_of_frame,
  .end_of_frame, .tx_start, .tx_remote, .tx_done, .irq, .mbox_ready_set, .mbox_rx_arm,
  .mbox_remote_wait);
`default_nettype wire

// file: cte_engine_model.sv
// Model of the CAN protocol engine that sends frames for the block.
// Assumes tx_start is a one-cycle pulse; answers after 2 or 9 cycles.
`timescale 1ns/1ns
`default_nettype none
module cte_engine_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_start,
  input wire logic slow,
  output logic tx_done
);
  logic [3:0] left_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_reg <= 4'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= (left_reg == 4'h1);
      if (tx_start) left_reg <= slow ? 4'h9 : 4'h2;
      else if (left_reg != 4'h0) left_reg <= left_reg - 4'h1;
    end
  end
endmodule // cte_engine_model
`default_nettype wire

// file: cte_core_tb.sv
// Self-checking bench for cte_core: register tasks over AXI4-Lite and event pulses.
// Assumes cte_engine_model answers transmits and the checker is bound in.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module cte_core_tb;
  localparam logic [11:0] SOF = 12'h001, EOFR = 12'h002, RXE = 12'h004, RXF = 12'h008;
  localparam logic [11:0] RXD = 12'h010, TXF = 12'h020, TXI = 12'h040, FDN = 12'h080;
  localparam logic [11:0] RXS = 12'h100, TXS = 12'h200, TCK = 12'h400, FRZ = 12'h800;
  logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, mr = 8'h00, ma = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [3:0] s_axi_wstrb = 4'hf, lv = 4'h0;
  logic [11:0] ev = 12'h000;
  logic [1:0] rr, br;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic tx_start, tx_remote, tx_done, irq;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0] mbox_rx_arm, mbox_remote_wait;
  wire logic [2:0] tx_mbox;
  int n_mismatch = 0, checks_done = 0;
  logic [3:0] txq[$];
  cte_core u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .bit_tick(ev[10]), .timer_freeze(ev[11]), .start_of_frame(ev[0]),
    .end_of_frame(ev[1]), .rx_error(ev[2]), .rx_error_in_flag(ev[3]), .rx_dominant_after_flag(ev[4]),
    .tx_error_flag_sent(ev[5]), .tx_error_exempt(lv[0]), .tx_error_in_flag(ev[6]), .flag_done(ev[7]),
    .flag_passive(lv[1]), .bus_dominant(lv[2]), .transmitting(lv[3]), .rx_success(ev[8]),
    .tx_success(ev[9]), .mbox_ready_set(mr), .mbox_abort_set(ma), .tx_done, .mbox_rx_arm,
    .mbox_remote_wait, .tx_start, .tx_mbox, .tx_remote, .irq);
  cte_engine_model u_eng (.aclk, .aresetn, .tx_start, .slow, .tx_done);
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (tx_start) txq.push_back({tx_remote, tx_mbox});
  task complete_run;
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task timeout;
    n_mismatch++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 40) timeout();
  endtask
  task automatic rdt(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 40) timeout();
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    rdt(a);
    `CHK(rd, e)
  endtask
  task automatic ec(input logic [7:0] rx_error_count, input logic [7:0] tx_error_count);
    rdchk(8'h14, {8'h00, tx_error_count, 8'h00, rx_error_count});
  endtask
  task automatic pulse(input logic [11:0] m);
    @(posedge aclk);
    ev <= m;
    @(posedge aclk);
    ev <= 12'h000;
  endtask
  task automatic ticks(input int n);
    repeat (n) pulse(TCK);
  endtask
  task automatic lvl(input logic [3:0] v);
    @(posedge aclk);
    lv <= v;
  endtask
  initial begin
    int n;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(8'h0c, 32'h0);
    rdchk(8'h10, 32'h0);
    ec(8'h00, 8'h00);
    rdchk(8'h18, 32'h0);
    rdt(8'h3c);
    `CHK({rr, rd}, {2'h2, 32'h0})
    wr(8'h3c, 32'h0);
    `CHK(br, 2'h2)
    wr(8'h00, 32'h1);
    `CHK(br, 2'h0)
    ticks(3);
    rdchk(8'h0c, 32'h3);
    pulse(FRZ);
    ticks(2);
    rdchk(8'h0c, 32'h3);
    wr(8'h18, 32'h8000_0000);
    rdchk(8'h0c, 32'h0);
    ticks(4);
    rdchk(8'h0c, 32'h4);
    wr(8'h04, 32'h1);
    pulse(SOF);
    @(posedge aclk);
    `CHK(irq, 1'b1)
    rdchk(8'h10, 32'h4);
    rdchk(8'h08, 32'h1);
    rdchk(8'h08, 32'h0);
    `CHK(irq, 1'b0)
    pulse(EOFR);
    rdchk(8'h08, 32'h0);
    wr(8'h00, 32'h3);
    ticks(1);
    pulse(EOFR);
    rdchk(8'h10, 32'h5);
    wr(8'h00, 32'h2);
    wr(8'h00, 32'h3);
    rdchk(8'h10, 32'h0);
    repeat (3) pulse(RXE);
    ec(8'd3, 8'd0);
    pulse(RXE | RXF);
    ec(8'd11, 8'd0);
    pulse(RXD);
    ec(8'd19, 8'd0);
    pulse(RXS);
    ec(8'd18, 8'd0);
    repeat (14) pulse(RXD);
    pulse(RXS);
    ec(8'd119, 8'd0);
    pulse(TXF);
    ec(8'd119, 8'd8);
    lvl(4'h1);
    pulse(TXF);
    ec(8'd119, 8'd8);
    lvl(4'h0);
    pulse(TXI);
    ec(8'd119, 8'd16);
    pulse(TXS);
    ec(8'd119, 8'd15);
    lvl(4'h2);
    pulse(FDN);
    lvl(4'h6);
    ticks(7);
    ec(8'd119, 8'd15);
    ticks(1);
    ec(8'd127, 8'd15);
    ticks(8);
    ec(8'd135, 8'd15);
    lvl(4'h0);
    ticks(1);
    lvl(4'h8);
    pulse(FDN);
    lvl(4'hc);
    ticks(13);
    ec(8'd135, 8'd15);
    ticks(1);
    ec(8'd135, 8'd23);
    lvl(4'h0);
    ticks(1);
    @(posedge aclk);
    mr <= 8'h11;
    ma <= 8'h01;
    @(posedge aclk);
    mr <= 8'h00;
    ma <= 8'h00;
    rdchk(8'h24, 32'h0111);
    wr(8'h1c, 32'h11b1b);
    wr(8'h20, 32'h225);
    slow <= 1'b1;
    wr(8'h18, 32'h3f);
    rdchk(8'h24, 32'h0);
    `CHK({mbox_rx_arm, mbox_remote_wait}, 16'h3008)
    n = 0;
    while (txq.size() < 3 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 300) timeout();
    `CHK(txq[0], 4'h1)
    `CHK(txq[1], 4'ha)
    `CHK(txq[2], 4'h0)
    wr(8'h18, 32'h0);
    repeat (10) @(posedge aclk);
    `CHK(txq.size(), 3)
    slow <= 1'b0;
    wr(8'h18, 32'h3);
    n = 0;
    while (txq.size() < 5 && n < 300) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 300) timeout();
    `CHK({txq[3], txq[4]}, 8'h10)
    @(posedge aclk);
    mr <= 8'h38;
    @(posedge aclk);
    mr <= 8'h00;
    @(posedge aclk);
    `CHK({mbox_rx_arm, mbox_remote_wait}, 16'h0)
    complete_run();
  end
endmodule // cte_core_tb
`default_nettype wire
